// ===== tchs_regs.svh
`ifndef TCHS_REGS_SVH
`define TCHS_REGS_SVH

// register word addresses on the plain register port
`define TCHS_ADDR_W          4
`define TCHS_OFF_REQUEST     4'h0
`define TCHS_OFF_PRIORITY    4'h1
`define TCHS_OFF_FUNCTION    4'h2
`define TCHS_OFF_SEQUENCE    4'h3
`define TCHS_OFF_IRQ_STATUS  4'h4
`define TCHS_OFF_IRQ_ENABLE  4'h5
`define TCHS_OFF_IRQ_CLEAR   4'h6
`define TCHS_OFF_ACTION      4'h7

`define TCHS_REQUEST_RESET   16'h0000
`define TCHS_PRIORITY_RESET  16'h0000
`define TCHS_FUNCTION_RESET  32'h0000_0000
`define TCHS_SEQUENCE_RESET  16'h0000

// time function codes
`define TCHS_FN_SYNCED_PWM   4'h7
`define TCHS_FN_DISCRETE     4'h8
`define TCHS_FN_PWM          4'h9
`define TCHS_FN_CAPTURE      4'ha
`define TCHS_FN_PERIOD       4'hb
`define TCHS_FN_ANGLE_PULSE  4'hc
`define TCHS_FN_STEPPER      4'hd
`define TCHS_FN_OUTPUT_MATCH 4'he
`define TCHS_FN_ACCUMULATOR  4'hf

// slot scheduler: 7 slots per round
`define TCHS_ROUND_LEN       3'h7
`define TCHS_SERVICE_CYCLES  4'h3

`endif

// ===== tchs_pkg.sv
package tchs_pkg;

    typedef enum logic [4:0] {
        TCHS_ACT_NONE        = 5'h00,
        TCHS_ACT_FORCE_HIGH  = 5'h01,
        TCHS_ACT_FORCE_LOW   = 5'h02,
        TCHS_ACT_INIT        = 5'h03,
        TCHS_ACT_UPDATE_PIN  = 5'h04,
        TCHS_ACT_HOST_PULSE  = 5'h05,
        TCHS_ACT_CONT_PULSE  = 5'h06,
        TCHS_ACT_IMM_UPDATE  = 5'h07,
        TCHS_ACT_STEP        = 5'h08,
        TCHS_ACT_FORCE_CHG   = 5'h09,
        TCHS_ACT_UNIMPL      = 5'h0a
    } tchs_action_type;

    typedef enum logic [3:0] {
        TCHS_MODE_NONE          = 4'h0,
        TCHS_MODE_ON_TRANSITION = 4'h1,
        TCHS_MODE_AT_MATCH_RATE = 4'h2,
        TCHS_MODE_ON_REQUEST    = 4'h3,
        TCHS_MODE_SINGLE        = 4'h4,
        TCHS_MODE_CONTINUOUS    = 4'h5,
        TCHS_MODE_ALL_ACTIONS   = 4'h6,
        TCHS_MODE_TIMEBASE_ONLY = 4'h7,
        TCHS_MODE_VARIANT       = 4'h8,
        TCHS_MODE_BY_ANGLE      = 4'h9,
        TCHS_MODE_BY_TIME       = 4'ha,
        TCHS_MODE_UNIMPL        = 4'hb
    } tchs_mode_type;

    // decoded service: what the channel does and in which variant
    typedef struct packed {
        logic            link;
        tchs_mode_type   mode;
        tchs_action_type action;
    } tchs_service_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tchs_bus_req_type;

    typedef enum logic [1:0] {
        TCHS_ST_IDLE    = 2'b00,
        TCHS_ST_SERVICE = 2'b01,
        TCHS_ST_DONE    = 2'b10
    } tchs_state_type;

endpackage : tchs_pkg

// ===== tchs_service.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "tchs_regs.svh"

module tchs_service
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [`TCHS_ADDR_W-1:0] addr,
    input  wire logic [15:0]             wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [15:0]             rdata,
    output logic                         irq,
    output logic                         svc_valid,
    output logic      [2:0]              svc_channel,
    output tchs_pkg::tchs_service_type   svc_info
);
    import tchs_pkg::*;

    // decode of one channel's request against its function and sequence
    function automatic tchs_service_type decode(input logic [3:0] fn, input logic [1:0] req,
                                                input logic [1:0] seq);
        tchs_service_type s;
        s.link   = 1'b0;
        s.mode   = TCHS_MODE_NONE;
        s.action = TCHS_ACT_UNIMPL;
        unique case (fn)
            `TCHS_FN_DISCRETE:
            begin
                unique case (req)
                    2'h1: s.action = TCHS_ACT_FORCE_HIGH;
                    2'h2: s.action = TCHS_ACT_FORCE_LOW;
                    2'h3: s.action = (seq == 2'h2) ? TCHS_ACT_UPDATE_PIN : TCHS_ACT_INIT;
                    2'h0: s.action = TCHS_ACT_NONE;
                endcase
                unique case (seq)
                    2'h0: s.mode = TCHS_MODE_ON_TRANSITION;
                    2'h1: s.mode = TCHS_MODE_AT_MATCH_RATE;
                    2'h2: s.mode = TCHS_MODE_ON_REQUEST;
                    2'h3: s.mode = TCHS_MODE_UNIMPL;
                endcase
            end
            `TCHS_FN_CAPTURE:
            begin
                s.action = (req == 2'h1) ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
                s.mode   = seq[0] ? TCHS_MODE_CONTINUOUS : TCHS_MODE_SINGLE;
                s.link   = seq[1];
            end
            `TCHS_FN_OUTPUT_MATCH:
            begin
                s.action = (req == 2'h1) ? TCHS_ACT_HOST_PULSE :
                           (req == 2'h3) ? TCHS_ACT_CONT_PULSE : TCHS_ACT_UNIMPL;
                s.mode   = seq[1] ? TCHS_MODE_TIMEBASE_ONLY : TCHS_MODE_ALL_ACTIONS;
            end
            `TCHS_FN_PWM:
                s.action = (req == 2'h1) ? TCHS_ACT_IMM_UPDATE :
                           (req == 2'h2) ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
            `TCHS_FN_STEPPER:
                s.action = (req == 2'h2) ? TCHS_ACT_INIT :
                           (req == 2'h3) ? TCHS_ACT_STEP : TCHS_ACT_UNIMPL;
            `TCHS_FN_SYNCED_PWM:
            begin
                s.action = (req == 2'h2) ? TCHS_ACT_INIT :
                           (req == 2'h3) ? TCHS_ACT_IMM_UPDATE : TCHS_ACT_UNIMPL;
                s.mode   = (seq == 2'h3) ? TCHS_MODE_UNIMPL : TCHS_MODE_VARIANT;
            end
            `TCHS_FN_PERIOD:
            begin
                s.action = (req == 2'h1) ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
                s.mode   = TCHS_MODE_VARIANT;
                s.link   = seq[1]; // high selects missing-transition detect
            end
            `TCHS_FN_ANGLE_PULSE:
            begin
                unique case (req)
                    2'h1: s.action = TCHS_ACT_IMM_UPDATE;
                    2'h2: s.action = TCHS_ACT_INIT;
                    2'h3: s.action = TCHS_ACT_FORCE_CHG;
                    2'h0: s.action = TCHS_ACT_NONE;
                endcase
                s.mode = seq[0] ? TCHS_MODE_BY_TIME : TCHS_MODE_BY_ANGLE;
            end
            `TCHS_FN_ACCUMULATOR:
            begin
                s.action = (req == 2'h2) ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
                s.mode   = TCHS_MODE_VARIANT;
                s.link   = seq[0];
            end
            default: s.action = TCHS_ACT_UNIMPL;
        endcase
        return s;
    endfunction : decode

    // priority weight per round of 7 slots
    function automatic logic [2:0] weight(input logic [1:0] pri);
        unique case (pri)
            2'b00: weight = 3'h0;
            2'b01: weight = 3'h1;
            2'b10: weight = 3'h2;
            2'b11: weight = 3'h4;
        endcase
    endfunction : weight

    logic [15:0] request;
    logic [15:0] next_request;
    logic [15:0] priority_half;
    logic [15:0] next_priority_half;
    logic [31:0] function_sel;
    logic [31:0] next_function_sel;
    logic [15:0] sequence_sel;
    logic [15:0] next_sequence_sel;
    logic [7:0]  irq_status;
    logic [7:0]  next_irq_status;
    logic [7:0]  irq_enable;
    logic [7:0]  next_irq_enable;
    logic [15:0] next_rdata;
    logic        next_irq;

    tchs_state_type   state;
    tchs_state_type   next_state;
    logic [2:0]       slot;
    logic [2:0]       next_slot;
    logic [2:0]       cur_ch;
    logic [2:0]       next_cur_ch;
    logic [3:0]       busy_cnt;
    logic [3:0]       next_busy_cnt;
    logic [2:0]       rr_ch;
    logic [2:0]       next_rr_ch;
    logic             next_svc_valid;
    tchs_service_type next_svc_info;
    logic [7:0]       done_mask;
    logic [7:0]       grantable;
    logic             grant_now;
    tchs_bus_req_type bus;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // a grant is being made this cycle, so its channel is already in service
    assign grant_now = (state == TCHS_ST_IDLE) && (grantable != 8'h00);

    // channel may take a slot when its pending and its weight covers the slot
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_grant
            assign grantable[g] = (request[2*g +: 2] != 2'b00) &&
                                  (slot < weight(priority_half[2*g +: 2]));
        end
    endgenerate

    always_comb
    begin
        next_state     = state;
        next_slot      = slot;
        next_cur_ch    = cur_ch;
        next_busy_cnt  = busy_cnt;
        next_rr_ch     = rr_ch;
        next_svc_valid = 1'b0;
        next_svc_info  = svc_info;
        done_mask      = 8'h00;
        unique case (state)
            TCHS_ST_IDLE:
            begin
                next_slot = (slot == `TCHS_ROUND_LEN - 3'h1) ? 3'h0 : slot + 3'h1;
                for (int i = 7; i >= 0; i--)
                begin
                    if (grantable[3'(rr_ch + 3'(i))])
                    begin
                        next_cur_ch = 3'(rr_ch + 3'(i));
                    end
                end
                if (grantable != 8'h00)
                begin
                    next_state    = TCHS_ST_SERVICE;
                    next_busy_cnt = `TCHS_SERVICE_CYCLES;
                    next_svc_info = decode(function_sel[4*next_cur_ch +: 4],
                                           request[2*next_cur_ch +: 2],
                                           sequence_sel[2*next_cur_ch +: 2]);
                    // unimplemented codes complete without any pin action
                    next_svc_valid = (next_svc_info.action != TCHS_ACT_UNIMPL);
                end
            end
            TCHS_ST_SERVICE:
            begin
                next_busy_cnt = busy_cnt - 4'h1;
                if (busy_cnt == 4'h1)
                begin
                    next_state = TCHS_ST_DONE;
                end
            end
            TCHS_ST_DONE:
            begin
                done_mask[cur_ch] = 1'b1;
                next_rr_ch        = cur_ch + 3'h1;
                next_state        = TCHS_ST_IDLE;
            end
            default: next_state = TCHS_ST_IDLE;
        endcase
    end

    always_comb
    begin
        next_request       = request;
        next_priority_half = priority_half;
        next_function_sel  = function_sel;
        next_sequence_sel  = sequence_sel;
        next_irq_enable    = irq_enable;
        next_irq_status    = irq_status;
        next_rdata         = 16'h0000;
        for (int c = 0; c < 8; c++)
        begin
            if (done_mask[c])
            begin
                next_request[2*c +: 2] = 2'b00;
            end
        end
        if (bus.wr)
        begin
            unique case (bus.addr)
                `TCHS_OFF_REQUEST:
                begin
                    for (int c = 0; c < 8; c++)
                    begin
                        // the field being serviced cannot be overwritten by the host;
                        // a code written in the grant cycle would be cleared unseen
                        if (!((state != TCHS_ST_IDLE || grant_now) && next_cur_ch == 3'(c)))
                        begin
                            next_request[2*c +: 2] = bus.wdata[2*c +: 2];
                        end
                    end
                end
                `TCHS_OFF_PRIORITY:   next_priority_half         = bus.wdata;
                `TCHS_OFF_FUNCTION:   next_function_sel[15:0]    = bus.wdata;
                `TCHS_OFF_ACTION:     next_function_sel[31:16]   = bus.wdata;
                `TCHS_OFF_SEQUENCE:   next_sequence_sel          = bus.wdata;
                `TCHS_OFF_IRQ_ENABLE: next_irq_enable            = bus.wdata[7:0];
                `TCHS_OFF_IRQ_CLEAR:  next_irq_status            = irq_status & ~bus.wdata[7:0];
                default:              next_request               = next_request;
            endcase
        end
        // completion set wins over a clear in the same cycle
        next_irq_status = next_irq_status | done_mask;
        if (bus.rd)
        begin
            unique case (bus.addr)
                `TCHS_OFF_REQUEST:    next_rdata = request;
                `TCHS_OFF_PRIORITY:   next_rdata = priority_half;
                `TCHS_OFF_FUNCTION:   next_rdata = function_sel[15:0];
                `TCHS_OFF_ACTION:     next_rdata = function_sel[31:16];
                `TCHS_OFF_SEQUENCE:   next_rdata = sequence_sel;
                `TCHS_OFF_IRQ_STATUS: next_rdata = {8'h00, irq_status};
                `TCHS_OFF_IRQ_ENABLE: next_rdata = {8'h00, irq_enable};
                default:              next_rdata = 16'h0000;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            request       <= `TCHS_REQUEST_RESET;
            priority_half <= `TCHS_PRIORITY_RESET;
            function_sel  <= `TCHS_FUNCTION_RESET;
            sequence_sel  <= `TCHS_SEQUENCE_RESET;
            irq_status    <= 8'h00;
            irq_enable    <= 8'h00;
            rdata         <= 16'h0000;
            irq           <= 1'b0;
            state         <= TCHS_ST_IDLE;
            slot          <= 3'h0;
            cur_ch        <= 3'h0;
            busy_cnt      <= 4'h0;
            rr_ch         <= 3'h0;
            svc_valid     <= 1'b0;
            svc_info      <= '{link: 1'b0, mode: TCHS_MODE_NONE, action: TCHS_ACT_NONE};
        end
        else
        begin
            request       <= next_request;
            priority_half <= next_priority_half;
            function_sel  <= next_function_sel;
            sequence_sel  <= next_sequence_sel;
            irq_status    <= next_irq_status;
            irq_enable    <= next_irq_enable;
            rdata         <= next_rdata;
            irq           <= next_irq;
            state         <= next_state;
            slot          <= next_slot;
            cur_ch        <= next_cur_ch;
            busy_cnt      <= next_busy_cnt;
            rr_ch         <= next_rr_ch;
            svc_valid     <= next_svc_valid;
            svc_info      <= next_svc_info;
        end
    end

    assign svc_channel = cur_ch;

endmodule : tchs_service

// ===== tchs_service_props.sv
`include "tchs_regs.svh"
module tchs_service_chk
(
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic [`TCHS_ADDR_W-1:0] addr,
    input wire logic [15:0]             wdata,
    input wire logic                    wr,
    input wire logic                    rd,
    input wire logic [15:0]             rdata,
    input wire logic                    irq,
    input wire logic                    svc_valid,
    input wire logic [2:0]              svc_channel,
    input wire tchs_pkg::tchs_service_type svc_info
);
    timeunit 1ns;
    timeprecision 1ps;
    import tchs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rdata_idle;
        !rd |=> rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
    property p_unmapped;
        rd && addr[3] |=> rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_clear_wo;
        rd && addr == `TCHS_OFF_IRQ_CLEAR |=> rdata == 16'h0000;
    endproperty
    a_clear_wo: assert property (p_clear_wo) else $error("clear register readable");
    property p_valid_gap;
        svc_valid |=> !svc_valid [*3];
    endproperty
    a_valid_gap: assert property (p_valid_gap) else $error("service pulses too close");
    property p_valid_impl;
        svc_valid |-> !(svc_info.action inside {TCHS_ACT_UNIMPL, TCHS_ACT_NONE});
    endproperty
    a_valid_impl: assert property (p_valid_impl) else $error("unimplemented request started");
    property p_step_mode;
        svc_valid && svc_info.action == TCHS_ACT_STEP |-> svc_info.mode == TCHS_MODE_NONE;
    endproperty
    a_step_mode: assert property (p_step_mode) else $error("step with a variant");
    property p_pulse_mode;
        svc_valid && svc_info.action inside {TCHS_ACT_HOST_PULSE, TCHS_ACT_CONT_PULSE}
            |-> svc_info.mode inside {TCHS_MODE_ALL_ACTIONS, TCHS_MODE_TIMEBASE_ONLY};
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) else $error("pulse variant wrong");
    property p_force_mode;
        svc_valid && svc_info.action == TCHS_ACT_FORCE_CHG |-> svc_info.mode inside {TCHS_MODE_BY_ANGLE, TCHS_MODE_BY_TIME};
    endproperty
    a_force_mode: assert property (p_force_mode) else $error("force change variant wrong");
    property p_irq_mask;
        wr && addr == `TCHS_OFF_IRQ_ENABLE && wdata == 16'h0000 |-> ##2 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
    c_svc: cover property (svc_valid);
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (rd && addr[3]);
endmodule : tchs_service_chk

// ===== tchs_host.sv
`include "tchs_regs.svh"
module tchs_host
(
    input  wire logic                  clk,
    input  wire logic [15:0]           rdata,
    output tchs_pkg::tchs_bus_req_type bus
);
    timeunit 1ns;
    timeprecision 1ps;
    import tchs_pkg::*;
    initial bus = '0;
    // released lines show the inverse so a stale value never matches
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{~a, ~d, 1'b0, 1'b0};
    endtask : write_reg
    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        bus <= '{a, bus.wdata, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '{~a, ~bus.wdata, 1'b0, 1'b0};
        @(negedge clk);
        d = rdata;
    endtask : read_reg
    task automatic wait_clear(input int ch, output logic [15:0] d);
        for (int k = 0; k < 50; k++)
        begin
            read_reg(`TCHS_OFF_REQUEST, d);
            if (d[2*ch +: 2] === 2'b00) break;
        end
    endtask : wait_clear
endmodule : tchs_host

// ===== tb.sv
`include "tchs_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("Error %0t got %h exp %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tchs_pkg::*;
    logic             clk;
    logic             rst;
    tchs_bus_req_type bus;
    logic [15:0]      rdata;
    logic             irq;
    logic             svc_valid;
    logic [2:0]       svc_channel;
    tchs_service_type svc_info;
    tchs_service_type last_info;
    logic [2:0]       last_ch;
    int               failures = 0;
    int               n_checks = 0;
    int               n_svc = 0;
    logic [3:0]       fns [9] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};

    tchs_service i_dut (.clk(clk), .rst(rst), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
        .rdata(rdata), .irq(irq), .svc_valid(svc_valid), .svc_channel(svc_channel), .svc_info(svc_info));
    tchs_host i_host (.clk(clk), .rdata(rdata), .bus(bus));

    function automatic tchs_action_type exp_act(logic [3:0] fn, logic [1:0] sq, logic [1:0] rq);
        case (fn)
            4'h8: return rq == 1 ? TCHS_ACT_FORCE_HIGH : rq == 2 ? TCHS_ACT_FORCE_LOW
                : sq == 2 ? TCHS_ACT_UPDATE_PIN : TCHS_ACT_INIT;
            4'ha, 4'hb: return rq == 1 ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
            4'he: return rq == 1 ? TCHS_ACT_HOST_PULSE : rq == 3 ? TCHS_ACT_CONT_PULSE : TCHS_ACT_UNIMPL;
            4'h9: return rq == 1 ? TCHS_ACT_IMM_UPDATE : rq == 2 ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
            4'hd: return rq == 2 ? TCHS_ACT_INIT : rq == 3 ? TCHS_ACT_STEP : TCHS_ACT_UNIMPL;
            4'h7: return rq == 2 ? TCHS_ACT_INIT : rq == 3 ? TCHS_ACT_IMM_UPDATE : TCHS_ACT_UNIMPL;
            4'hc: return rq == 1 ? TCHS_ACT_IMM_UPDATE : rq == 2 ? TCHS_ACT_INIT : TCHS_ACT_FORCE_CHG;
            default: return rq == 2 ? TCHS_ACT_INIT : TCHS_ACT_UNIMPL;
        endcase
    endfunction : exp_act

    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic run_case(input logic [3:0] fn, input logic [1:0] sq, rq, input int ch, input logic [1:0] pr,
                            input logic en);
        logic [15:0]     d;
        int              n0;
        tchs_action_type act;
        n0  = n_svc;
        act = exp_act(fn, sq, rq);
        i_host.write_reg(`TCHS_OFF_FUNCTION, {4{fn}});
        i_host.write_reg(`TCHS_OFF_ACTION, {4{fn}});
        i_host.write_reg(`TCHS_OFF_SEQUENCE, {8{sq}});
        i_host.write_reg(`TCHS_OFF_PRIORITY, {8{pr}});
        i_host.write_reg(`TCHS_OFF_IRQ_ENABLE, {8'h00, {8{en}}});
        i_host.write_reg(`TCHS_OFF_REQUEST, 16'(rq) << (2 * ch));
        i_host.wait_clear(ch, d);
        `CHK(d[2*ch +: 2], 2'b00)
        if (d[2*ch +: 2] !== 2'b00) test_done();
        `CHK(n_svc - n0, (act == TCHS_ACT_UNIMPL) ? 0 : 1)
        if (act != TCHS_ACT_UNIMPL)
        begin
            `CHK(last_ch, 3'(ch))
            `CHK(last_info.action, act)
            if (fn == 4'hc) `CHK(last_info.mode, sq[0] ? TCHS_MODE_BY_TIME : TCHS_MODE_BY_ANGLE)
            if (fn == 4'he) `CHK(last_info.mode, sq[1] ? TCHS_MODE_TIMEBASE_ONLY : TCHS_MODE_ALL_ACTIONS)
            if (fn == 4'ha) `CHK(last_info.link, sq[1])
            if (fn == 4'hf) `CHK(last_info.link, sq[0])
            if (fn == 4'h7) `CHK(last_info.mode, (sq == 2'h3) ? TCHS_MODE_UNIMPL : TCHS_MODE_VARIANT)
        end
        i_host.read_reg(`TCHS_OFF_IRQ_STATUS, d);
        `CHK(d, 16'h0001 << ch)
        `CHK(irq, en)
        i_host.write_reg(`TCHS_OFF_IRQ_CLEAR, 16'h00ff);
        i_host.read_reg(`TCHS_OFF_IRQ_STATUS, d);
        `CHK(d, 16'h0000)
        `CHK(irq, 1'b0)
    endtask : run_case

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (svc_valid === 1'b1)
        begin
            n_svc++;
            last_ch   = svc_channel;
            last_info = svc_info;
        end
    end

    initial
    begin
        #400000;
        failures++;
        test_done();
    end

    initial
    begin
        logic [15:0] d;
        logic [3:0]  fn;
        logic [1:0]  rq;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(32'h2e5d));
        i_host.write_reg(4'hf, 16'hffff);
        for (int a = 0; a < 16; a++)
        begin
            i_host.read_reg(4'(a), d);
            `CHK(d, 16'h0000)
        end
        // priority 00 must leave the request parked
        i_host.write_reg(`TCHS_OFF_FUNCTION, 16'h8888);
        i_host.write_reg(`TCHS_OFF_REQUEST, 16'h0040);
        repeat (20) i_host.read_reg(`TCHS_OFF_REQUEST, d);
        `CHK(d, 16'h0040)
        // withdraw the parked request so it cannot be served once priorities open
        i_host.write_reg(`TCHS_OFF_REQUEST, 16'h0000);
        for (int i = 0; i < 27; i++)
        begin
            rq = 2'(i % 3 + 1);
            fn = fns[i / 3];
            run_case(fn, 2'(i % 4), rq, i % 8, 2'(i % 3 + 1), 1'(i % 2));
        end
        for (int i = 0; i < 25; i++)
        begin
            fn = fns[$urandom % 9];
            rq = 2'($urandom % 3 + 1);
            run_case(fn, 2'($urandom % 4), rq, $urandom % 8,
                     2'($urandom % 3 + 1), 1'($urandom));
        end
        test_done();
    end
endmodule : tb

bind tchs_service tchs_service_chk i_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .svc_valid(svc_valid), .svc_channel(svc_channel), .svc_info(svc_info));
